// File: dv/scbs_checker.sv
// Purpose: Port assertions for the control bus target
// Assumes: SCL low and high for 4 or more clocks
// Notes: Bound into scbs_top
`timescale 1ns/1ns
module scbs_checker
   import scbs_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [SCBS_BAND_W-1:0] address_select_pin_i,
   input wire logic link_detect_i,
   input wire logic power_down_o,
   input wire logic [6:0] target_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   only_pull_low_a: assert property (sda_o == 1'b0) else $error("sda_o high");
   pull_on_low_a: assert property ($rose(sda_oe_o) |-> !scl_i) else $error("pull while SCL high");
   release_on_low_a: assert property ($fell(sda_oe_o) |-> !scl_i) else $error("release while SCL high");
   hold_while_high_a: assert property (scl_i [*4] |-> $stable(sda_oe_o)) else $error("SDA moved");
   start_no_pull_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |=> !sda_oe_o [*3])
      else $error("pull at start");
   link_keeps_up_a: assert property (link_detect_i [*5] |-> !power_down_o) else $error("down with link");
   down_cause_a: assert property ($rose(power_down_o) |-> !$past(link_detect_i, 2))
      else $error("down without cause");
   quiet_reset_a: assert property ($fell(reset_i) |-> !sda_oe_o [*4]) else $error("pull after reset");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind scbs_top scbs_checker u_scbs_checker (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .address_select_pin_i(address_select_pin_i),
   .link_detect_i(link_detect_i), .power_down_o(power_down_o), .target_addr_o(target_addr_o));

// File: dv/scbs_host_model.sv
// Purpose: Bus host model driving SCL and pulling SDA
// Assumes: SDA level resolved by the bench with a pull-up
// Notes: hp is the half bit time in clocks, 4 or more
`timescale 1ns/1ns
module scbs_host_model (
   input wire logic clock_i,
   input wire logic sda_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic pull_o
);
   int hp = 8;
   int stalls = 0;
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #5;
   endtask
   task automatic bitx(input logic b, output logic r);
      pull_o = !b;
      tick(hp);
      scl_o = 1'b1;
      tick(hp);
      for (int w = 0; w < 64 && !scl_i; w++) tick(1);
      if (!scl_i) stalls++;
      r = sda_i;
      scl_o = 1'b0;
      tick(2);
   endtask
   task automatic start();
      pull_o = 1'b0;
      tick(hp);
      scl_o = 1'b1;
      tick(hp);
      pull_o = 1'b1;
      tick(hp);
      scl_o = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      pull_o = 1'b1;
      tick(hp);
      scl_o = 1'b1;
      tick(hp);
      pull_o = 1'b0;
      tick(hp);
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(last, r);
      ack = !r;
   endtask
endmodule

// File: dv/test_serial_control_bus_slave.sv
// Purpose: Self-checking bench for the control bus target
// Assumes: Host model drives the bus, bench drives band and link
// Notes: Bands 0 to 10, then one random band; random register data from a fixed seed
`timescale 1ns/1ns
module test_serial_control_bus_slave
   import scbs_pkg::*;
;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [SCBS_BAND_W-1:0] band = 4'h0;
   logic link = 1'b1;
   logic sda_o, sda_oe_o, power_down_o, scl, pull, sda, ak;
   logic [6:0] target_addr_o, a, na;
   logic [7:0] q, v;
   int miscompares = 0;
   int n_compared = 0;
   int seed = 32'hB8AE;
   assign sda = !(pull || (sda_oe_o && !sda_o));
   always #25 clock_i = !clock_i;
   scbs_top u_scbs_top (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .address_select_pin_i(band), .link_detect_i(link), .power_down_o(power_down_o),
      .target_addr_o(target_addr_o));
   scbs_host_model u_host (.clock_i(clock_i), .sda_i(sda), .scl_i(scl), .scl_o(scl), .pull_o(pull));
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] exp_addr(input logic [3:0] b);
      if (b == 4'h0) return 7'h0C;
      if (b > 4'h9) return 7'h1B;
      return 7'h12 + {3'h0, b};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [6:0] ad, input logic [7:0] off, input logic [7:0] d, input int n);
      u_host.start();
      u_host.xfer({ad, 1'b0}, 1'b1, q, ak);
      chk({7'h0, ak}, {7'h0, n > 0});
      if (n > 0) begin
         u_host.xfer(off, 1'b1, q, ak);
         if (n > 1) chk({7'h0, ak}, 8'h01);
         u_host.xfer(d, 1'b1, q, ak);
         if (n > 2) chk({7'h0, ak}, 8'h01);
      end
      u_host.stop();
   endtask
   task automatic rreg(input logic [6:0] ad, input logic [7:0] off, input logic [7:0] exp);
      u_host.start();
      u_host.xfer({ad, 1'b0}, 1'b1, q, ak);
      u_host.xfer(off, 1'b1, q, ak);
      u_host.start();
      u_host.xfer({ad, 1'b1}, 1'b1, q, ak);
      chk({7'h0, ak}, 8'h01);
      u_host.xfer(8'hFF, 1'b1, q, ak);
      u_host.stop();
      chk(q, exp);
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clock_i);
      #5 reset_i = 1'b0;
      for (int b = 0; b < 12; b++) begin
         band = (b < 11) ? 4'(b) : 4'($random(seed));
         u_host.hp = b[0] ? 4 : 8;
         u_host.tick(8);
         a = exp_addr(band);
         chk({1'b0, target_addr_o}, {1'b0, a});
         wreg(a + 7'h01, 8'h00, 8'h00, 0);
         rreg(a, SCBS_REG_ADDR_CFG, {a, 1'b0});
      end
      wreg(a, SCBS_REG_ADDR_CFG, 8'h54, 3);
      rreg(a, SCBS_REG_ADDR_CFG, {a, 1'b0});
      na = {3'b100, 4'($random(seed))};
      wreg(a, SCBS_REG_ADDR_CFG, 8'h01, 3);
      wreg(a, SCBS_REG_ADDR_CFG, {na, 1'b1}, 3);
      chk({1'b0, target_addr_o}, {1'b0, na});
      rreg(na, SCBS_REG_ADDR_CFG, {na, 1'b1});
      for (int i = 0; i < 4; i++) begin
         v = (8'($random(seed)) & 8'hFC) | {i == 0, 7'h00};
         wreg(na, SCBS_REG_RESET_CTL, v, 3);
         rreg(na, SCBS_REG_RESET_CTL, v & 8'h80);
         link = i[0];
         u_host.tick(8);
         chk({7'h0, power_down_o}, {7'h0, v[7] & !link});
      end
      wreg(na, SCBS_REG_RESET_CTL, 8'h81, 3);
      rreg(na, SCBS_REG_RESET_CTL, 8'h80);
      wreg(na, SCBS_REG_RESET_CTL, 8'h82, 3);
      u_host.tick(8);
      chk({1'b0, target_addr_o}, {1'b0, a});
      rreg(a, SCBS_REG_RESET_CTL, 8'h00);
      rreg(a, 8'h05, 8'h00);
      chk(8'(u_host.stalls), 8'h00);
      print_verdict();
   end
   initial begin
      repeat (100000) @(posedge clock_i);
      miscompares++;
      print_verdict();
   end
endmodule

// File: hw/scbs_addr_map.sv
// Purpose: Map the address-select band to a 7-bit target address
// Assumes: Band code from an outside comparator, 0 = lowest ratio
// Notes: Out-of-range codes take the top address
`timescale 1ns/1ns
module scbs_addr_map
   import scbs_pkg::*;
(
   input wire logic [SCBS_BAND_W-1:0] band_i,
   output logic [6:0] addr_o
);
   always_comb begin
      if (band_i == '0) begin
         addr_o = SCBS_ADDR_LOW;
      end else if (band_i > SCBS_BAND_LAST) begin
         addr_o = SCBS_ADDR_BASE + 7'(SCBS_BAND_LAST - SCBS_BAND_ONE);
      end else begin
         addr_o = SCBS_ADDR_BASE + 7'(band_i - SCBS_BAND_ONE);
      end
   end
endmodule

// File: hw/scbs_pkg.sv
// Purpose: Constants for the serial control bus target
// Assumes: 20 MHz system clock
// Notes: Register map, address table and field positions
package scbs_pkg;
   localparam logic [7:0] SCBS_REG_ADDR_CFG = 8'h00;
   localparam logic [7:0] SCBS_REG_RESET_CTL = 8'h01;
   localparam int SCBS_OVERRIDE_BIT = 0;
   localparam int SCBS_AUTO_PD_BIT = 7;
   localparam int SCBS_FULL_RST_BIT = 1;
   localparam int SCBS_KEEP_RST_BIT = 0;
   localparam logic [7:0] SCBS_RESET_CTL_MASK = 8'h80;
   localparam logic [7:0] SCBS_RESET_CTL_DEFAULT = 8'h00;
   localparam int SCBS_BAND_W = 4;
   localparam int SCBS_BANDS = 10;
   localparam logic [6:0] SCBS_ADDR_LOW = 7'h0C;
   localparam logic [6:0] SCBS_ADDR_BASE = 7'h13;
   localparam logic [3:0] SCBS_BAND_ONE = 4'h1;
   localparam logic [3:0] SCBS_BAND_LAST = 4'h9;
   localparam logic [2:0] SCBS_BIT_LAST = 3'h7;
   typedef enum logic [2:0] {
      SCBS_IDLE = 3'b000,
      SCBS_ADDR = 3'b001,
      SCBS_ACK = 3'b010,
      SCBS_WDATA = 3'b011,
      SCBS_RDATA = 3'b100,
      SCBS_RACK = 3'b101
   } scbs_state_t;
endpackage

// File: hw/scbs_top.sv
// Purpose: Serial control bus target with address and reset registers
// Assumes: SCL and SDA sampled by the 20 MHz clock; band code is static
// Notes: Open-drain SDA as in/out/enable; SCL is never stretched
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Select pin ratio picks one of ten addresses
// - Addresses 0x0C, then 0x13 to 0x1B
// - SDA falls while SCL high opens transfer
// - SDA rises while SCL high ends transfer
// - Track start, repeated start and stop
// - Matching address is acknowledged with SDA low
// - Other address leaves SDA released
// - Each written data byte is acknowledged
// - Only pull low or release the lines
// - Address bits 7:1 writable only with override
// - Override bit picks register or pin address
// - Bit 7 enables power down without link
// - Bit 1 resets logic and registers, self-clears
// - Bit 0 resets logic only, self-clears
module scbs_top
   import scbs_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [SCBS_BAND_W-1:0] address_select_pin_i,
   input wire logic link_detect_i,
   output logic power_down_o,
   output logic [6:0] target_addr_o
);
   //////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_q;
   logic sda_q;
   logic [SCBS_BAND_W-1:0] band_meta;
   logic [SCBS_BAND_W-1:0] band_sync;
   logic link_meta;
   logic link_sync;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         band_meta <= '0;
         band_sync <= '0;
         link_meta <= 1'b0;
         link_sync <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
         band_meta <= address_select_pin_i;
         band_sync <= band_meta;
         link_meta <= link_detect_i;
         link_sync <= link_meta;
      end
   end
   wire logic scl_s = scl_sync[1];
   wire logic sda_s = sda_sync[1];
   wire logic scl_rise = scl_s & ~scl_q;
   wire logic scl_fall = ~scl_s & scl_q;
   wire logic start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire logic stop_det = scl_s & scl_q & ~sda_q & sda_s;

   //////////////////////////////////////////////////////////////////////////
   // Address selection
   logic [6:0] pin_addr;
   scbs_addr_map u_map (
      .band_i(band_sync),
      .addr_o(pin_addr)
   );

   //////////////////////////////////////////////////////////////////////////
   // Registers and self-clearing resets
   logic [7:0] addr_cfg;
   logic [7:0] reset_ctl;
   logic soft_full;
   logic soft_keep;
   logic full_pend;
   logic keep_pend;
   logic wr_en;
   logic [7:0] wr_ofs;
   logic [7:0] shift;
   logic pin_loaded;
   wire logic logic_rst = soft_full | soft_keep;
   wire logic [6:0] own_addr = addr_cfg[SCBS_OVERRIDE_BIT] ? addr_cfg[7:1] : pin_addr;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         addr_cfg <= '0;
         reset_ctl <= SCBS_RESET_CTL_DEFAULT;
         pin_loaded <= 1'b0;
      end else if (soft_full) begin
         addr_cfg <= '0;
         reset_ctl <= SCBS_RESET_CTL_DEFAULT;
         pin_loaded <= 1'b0;
      end else begin
         if (!addr_cfg[SCBS_OVERRIDE_BIT]) begin
            addr_cfg[7:1] <= pin_addr;
            pin_loaded <= 1'b1;
         end
         if (wr_en && wr_ofs == SCBS_REG_ADDR_CFG) begin
            addr_cfg[SCBS_OVERRIDE_BIT] <= shift[SCBS_OVERRIDE_BIT];
            if (addr_cfg[SCBS_OVERRIDE_BIT]) begin
               addr_cfg[7:1] <= shift[7:1];
            end
         end
         if (wr_en && wr_ofs == SCBS_REG_RESET_CTL) begin
            reset_ctl <= shift & SCBS_RESET_CTL_MASK;
         end
      end
   end
   // Resets wait for the end of the ACK bit so the host still sees its ACK
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         full_pend <= 1'b0;
         keep_pend <= 1'b0;
         soft_full <= 1'b0;
         soft_keep <= 1'b0;
      end else begin
         if (wr_en && wr_ofs == SCBS_REG_RESET_CTL) begin
            full_pend <= shift[SCBS_FULL_RST_BIT];
            keep_pend <= shift[SCBS_KEEP_RST_BIT];
         end else if (scl_fall || stop_det) begin
            full_pend <= 1'b0;
            keep_pend <= 1'b0;
         end
         soft_full <= full_pend && (scl_fall || stop_det);
         soft_keep <= keep_pend && (scl_fall || stop_det);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Bus protocol engine
   scbs_state_t state;
   logic [2:0] bit_cnt;
   logic byte_full;
   logic rw_read;
   logic ofs_phase;
   logic [7:0] ofs;
   logic sda_pull;
   wire logic [7:0] rd_data = (ofs == SCBS_REG_ADDR_CFG) ? addr_cfg :
                              (ofs == SCBS_REG_RESET_CTL) ? reset_ctl : '0;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state <= SCBS_IDLE;
         bit_cnt <= '0;
         byte_full <= 1'b0;
         shift <= '0;
         rw_read <= 1'b0;
         ofs_phase <= 1'b0;
         ofs <= '0;
         wr_en <= 1'b0;
         wr_ofs <= '0;
         sda_pull <= 1'b0;
      end else if (logic_rst) begin
         state <= SCBS_IDLE;
         bit_cnt <= '0;
         wr_en <= 1'b0;
         sda_pull <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         if (stop_det) begin
            state <= SCBS_IDLE;
            sda_pull <= 1'b0;
         end else if (start_det) begin
            state <= SCBS_ADDR;
            bit_cnt <= '0;
            byte_full <= 1'b0;
            sda_pull <= 1'b0;
         end else begin
            case (state)
               SCBS_IDLE: begin
                  sda_pull <= 1'b0;
               end
               SCBS_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 3'h1;
                     byte_full <= (bit_cnt == SCBS_BIT_LAST);
                  end
                  // The SCL fall that ends START must not count as a byte
                  if (scl_fall && byte_full) begin
                     byte_full <= 1'b0;
                     if (shift[7:1] == own_addr) begin
                        rw_read <= shift[0];
                        ofs_phase <= ~shift[0];
                        sda_pull <= 1'b1;
                        state <= SCBS_ACK;
                     end else begin
                        state <= SCBS_IDLE;
                     end
                  end
               end
               SCBS_ACK: begin
                  if (scl_fall) begin
                     sda_pull <= rw_read ? ~rd_data[7] : 1'b0;
                     shift <= rd_data;
                     bit_cnt <= '0;
                     state <= rw_read ? SCBS_RDATA : SCBS_WDATA;
                  end
               end
               SCBS_WDATA: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 3'h1;
                  end
                  if (scl_fall && bit_cnt == '0) begin
                     sda_pull <= 1'b1;
                     state <= SCBS_ACK;
                     if (ofs_phase) begin
                        ofs <= shift;
                        ofs_phase <= 1'b0;
                     end else begin
                        wr_en <= 1'b1;
                        wr_ofs <= ofs;
                        ofs <= ofs + 8'h01;
                     end
                  end
               end
               SCBS_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt == SCBS_BIT_LAST) begin
                        sda_pull <= 1'b0;
                        ofs <= ofs + 8'h01;
                        state <= SCBS_RACK;
                     end else begin
                        sda_pull <= ~shift[6];
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'h1;
                     end
                  end
               end
               SCBS_RACK: begin
                  if (scl_rise) begin
                     state <= sda_s ? SCBS_IDLE : SCBS_ACK;
                  end
               end
               default: begin
                  state <= SCBS_IDLE;
               end
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         power_down_o <= 1'b0;
         target_addr_o <= '0;
      end else begin
         sda_o <= 1'b0;
         sda_oe_o <= sda_pull;
         power_down_o <= reset_ctl[SCBS_AUTO_PD_BIT] & ~link_sync;
         target_addr_o <= pin_loaded ? own_addr : pin_addr;
      end
   end
endmodule
